// ==== ptrmd_cfg.svh ====
/*
 * Offsets, field positions, reset values and counts for the PCI target
 * register map decoder.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef PTRMD_CFG_SVH
`define PTRMD_CFG_SVH

// Window and base address handling
`define PTRMD_WIN_MSB      31
`define PTRMD_WIN_LSB      20
`define PTRMD_BAR_CFG_OFF  8'h10
`define PTRMD_BAR_MASK     32'hFFF0_0000
`define PTRMD_GRP_STRIDE   16'h0800
`define PTRMD_GRP_MSB      13
`define PTRMD_GRP_LSB      11
`define PTRMD_GRP_LIMIT    6'h00

// Offsets inside one group, group 0 values
`define PTRMD_OFF_GBP      11'h000
`define PTRMD_OFF_DAC      11'h004
`define PTRMD_OFF_SRQ      11'h008
`define PTRMD_OFF_ISTAT    11'h00C
`define PTRMD_OFF_TXSLOT   11'h200
`define PTRMD_OFF_TXSUB    11'h280
`define PTRMD_OFF_TXCCFG   11'h380
`define PTRMD_OFF_RXSLOT   11'h400
`define PTRMD_OFF_RXSUB    11'h480
`define PTRMD_OFF_RXCCFG   11'h580
`define PTRMD_OFF_RAM_END  11'h600
`define PTRMD_OFF_GLOBAL   11'h600
`define PTRMD_OFF_IQ       11'h604
`define PTRMD_OFF_GRPCFG   11'h60C
`define PTRMD_OFF_MPROT    11'h610
`define PTRMD_OFF_MLEN     11'h614
`define PTRMD_OFF_PCFG     11'h618
`define PTRMD_OFF_RXST     11'h640
`define PTRMD_OFF_TXST     11'h644

// Reset and fixed read values, group count and RAM size
`define PTRMD_RST_REG      32'h0000_0000
`define PTRMD_RD_ONES      32'hFFFF_FFFF
`define PTRMD_RD_ZERO      32'h0000_0000
`define PTRMD_GROUPS       8
`define PTRMD_RAM_AW       11
`define PTRMD_RAM_WORDS    2048

`endif

// ==== ptrmd_pkg.sv ====
/*
 * Types shared by the register map decoder and its internal RAM.
 * Assumes ptrmd_cfg.svh is on the include path.
 */
`include "ptrmd_cfg.svh"

package ptrmd_pkg;

    // Register classes reached through function 0
    typedef enum logic [3:0] {
        K_NONE, K_GBP, K_DAC, K_SRQ, K_ISTAT, K_TXWO, K_RAM, K_GLOBAL,
        K_IQ, K_GRPCFG, K_MPROT, K_MLEN, K_PCFG, K_RXST, K_TXST
    } ptrmd_kind_type;

    typedef struct packed {
        ptrmd_kind_type kind;
        logic [2:0]     group;
    } ptrmd_dec_type;

    // Memory cycle seen by the target
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        self_master;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } ptrmd_req_type;

    typedef struct packed {
        logic        valid;
        logic        claimed;
        logic [31:0] data;
    } ptrmd_resp_type;

    // Configuration cycle for the base address registers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        func;
        logic [7:0]  offset;
        logic [31:0] data;
    } ptrmd_cfg_type;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [19:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } ptrmd_xbp_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RAMRD = 2'b01,
        ST_XBP   = 2'b10
    } ptrmd_state_type;

endpackage : ptrmd_pkg

// ==== ptrmd_ram.sv ====
/*
 * Internal map RAM: slot maps, subchannel maps and channel tables for
 * all eight groups, with byte enables and a registered read port.
 * Assumes a single clock and one access per cycle.
 */
`timescale 1ns/1ps
`include "ptrmd_cfg.svh"

module ptrmd_ram
(
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       we,
    input  wire logic [3:0]                 be,
    input  wire logic [`PTRMD_RAM_AW-1:0]   addr,
    input  wire logic [31:0]                wdata,
    output logic      [31:0]                rdata_r
);
    import ptrmd_pkg::*;

    logic [31:0] mem [`PTRMD_RAM_WORDS];

    ////////////////////////////////////////////////////////////////////
    // Byte-lane writes; array has no reset, contents are undefined
    always_ff @(posedge clk)
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (we && be[b])
                mem[addr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
    end

    // Read data always comes out of a register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_r <= `PTRMD_RD_ZERO;
        else
            rdata_r <= mem[addr];
    end

endmodule : ptrmd_ram

// ==== ptrmd_decoder.sv ====
/*
 * PCI target address decode and register map for two memory functions.
 * Function 0 reaches the group register map, function 1 the expansion
 * bus. Assumes requests are synchronous to clk and held until accepted.
 */
`timescale 1ns/1ps
`include "ptrmd_cfg.svh"

module ptrmd_decoder
(
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire ptrmd_pkg::ptrmd_req_type req,
    output logic                          req_ready,
    output ptrmd_pkg::ptrmd_resp_type     resp,
    input  wire ptrmd_pkg::ptrmd_cfg_type cfg_req,
    output logic      [31:0]              cfg_rdata,
    output ptrmd_pkg::ptrmd_xbp_type      xbp_out,
    input  wire logic                     xbp_ack,
    input  wire logic [31:0]              xbp_rdata,
    output logic                          srq_start,
    output logic      [2:0]               srq_group,
    output logic      [31:0]              srq_cmd,
    input  wire logic [31:0]              rx_selftest_in,
    input  wire logic [31:0]              tx_selftest_in
);
    import ptrmd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Byte-enable merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                m[b*8 +: 8] = wd[b*8 +: 8];
        end
        return m;
    endfunction : merge

    // Offset to register class; the group field is ignored for shared
    // registers, which makes groups 1-7 alias group 0 for them
    function automatic ptrmd_dec_type decode(input logic [19:0] off);
        ptrmd_dec_type d;
        logic [10:0]   lw;
        lw      = {off[10:2], 2'b00};
        d.group = off[`PTRMD_GRP_MSB:`PTRMD_GRP_LSB];
        d.kind  = K_NONE;
        if (off[19:14] == `PTRMD_GRP_LIMIT)
        begin
            if (lw >= `PTRMD_OFF_TXSLOT && lw < `PTRMD_OFF_RAM_END)
                d.kind = (lw < `PTRMD_OFF_TXCCFG) ? K_TXWO : K_RAM;
            else
            begin
                case (lw)
                    `PTRMD_OFF_GBP:    d.kind = K_GBP;
                    `PTRMD_OFF_DAC:    d.kind = K_DAC;
                    `PTRMD_OFF_SRQ:    d.kind = K_SRQ;
                    `PTRMD_OFF_ISTAT:  d.kind = K_ISTAT;
                    `PTRMD_OFF_GLOBAL: d.kind = K_GLOBAL;
                    `PTRMD_OFF_IQ:     d.kind = K_IQ;
                    `PTRMD_OFF_GRPCFG: d.kind = K_GRPCFG;
                    `PTRMD_OFF_MPROT:  d.kind = K_MPROT;
                    `PTRMD_OFF_MLEN:   d.kind = K_MLEN;
                    `PTRMD_OFF_PCFG:   d.kind = K_PCFG;
                    `PTRMD_OFF_RXST:   d.kind = K_RXST;
                    `PTRMD_OFF_TXST:   d.kind = K_TXST;
                    default:           d.kind = K_NONE;
                endcase
            end
        end
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////
    // Storage

    ptrmd_state_type        state_r;
    ptrmd_state_type        state_nxt;
    logic [31:0]            bar0_r;
    logic [31:0]            bar1_r;
    logic [7:0][31:0]       gbp_r;
    logic [7:0][31:0]       srq_r;
    logic [7:0][31:0]       grpcfg_r;
    logic [7:0][31:0]       mprot_r;
    logic [7:0][31:0]       mlen_r;
    logic [7:0][31:0]       pcfg_r;
    logic [31:0]            dac_r;
    logic [31:0]            istat_r;
    logic [31:0]            global_r;
    logic [31:0]            iq_r;
    logic [31:0]            ram_rdata;
    logic [31:0]            rd_nxt;
    logic [`PTRMD_RAM_AW-1:0] ram_addr;
    logic                   ram_we;
    logic                   accept;
    logic                   hit0;
    logic                   hit1;
    logic                   wr0;
    ptrmd_dec_type          dec;

    ////////////////////////////////////////////////////////////////////
    // Claim decode; a cycle we mastered ourselves is never claimed
    assign accept = req.valid && req_ready;
    assign hit0   = !req.self_master &&
                    req.addr[`PTRMD_WIN_MSB:`PTRMD_WIN_LSB] ==
                    bar0_r[`PTRMD_WIN_MSB:`PTRMD_WIN_LSB];
    assign hit1   = !req.self_master && !hit0 &&
                    req.addr[`PTRMD_WIN_MSB:`PTRMD_WIN_LSB] ==
                    bar1_r[`PTRMD_WIN_MSB:`PTRMD_WIN_LSB];
    assign dec    = decode(req.addr[19:0]);
    assign wr0    = accept && hit0 && req.write;

    // Map area index: group in the top bits, word inside the group
    assign ram_addr = {dec.group,
                       8'(req.addr[10:2] - 9'(`PTRMD_OFF_TXSLOT >> 2))};
    assign ram_we   = wr0 && (dec.kind == K_RAM || dec.kind == K_TXWO);

    ptrmd_ram u_ram
    (
        .clk     (clk),
        .reset   (reset),
        .we      (ram_we),
        .be      (req.be),
        .addr    (ram_addr),
        .wdata   (req.data),
        .rdata_r (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Base address registers; low 20 bits fixed at zero for 1 MB
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bar0_r <= `PTRMD_RST_REG;
            bar1_r <= `PTRMD_RST_REG;
        end
        else if (cfg_req.valid && cfg_req.write &&
                 cfg_req.offset == `PTRMD_BAR_CFG_OFF)
        begin
            if (cfg_req.func)
                bar1_r <= cfg_req.data & `PTRMD_BAR_MASK;
            else
                bar0_r <= cfg_req.data & `PTRMD_BAR_MASK;
        end
    end

    // Configuration read-back; other config offsets read zero here
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cfg_rdata <= `PTRMD_RD_ZERO;
        else if (cfg_req.valid && !cfg_req.write)
        begin
            if (cfg_req.offset != `PTRMD_BAR_CFG_OFF)
                cfg_rdata <= `PTRMD_RD_ZERO;
            else
                cfg_rdata <= cfg_req.func ? bar1_r : bar0_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-group registers, one copy for each group
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gbp_r    <= '0;
            srq_r    <= '0;
            grpcfg_r <= '0;
            mprot_r  <= '0;
            mlen_r   <= '0;
            pcfg_r   <= '0;
        end
        else if (wr0)
        begin
            case (dec.kind)
                K_GBP:
                    gbp_r[dec.group] <= merge(gbp_r[dec.group],
                                              req.data, req.be);
                K_SRQ:
                    srq_r[dec.group] <= merge(srq_r[dec.group],
                                              req.data, req.be);
                K_GRPCFG:
                    grpcfg_r[dec.group] <= merge(grpcfg_r[dec.group],
                                                 req.data, req.be);
                K_MPROT:
                    mprot_r[dec.group] <= merge(mprot_r[dec.group],
                                                req.data, req.be);
                K_MLEN:
                    mlen_r[dec.group] <= merge(mlen_r[dec.group],
                                               req.data, req.be);
                K_PCFG:
                    pcfg_r[dec.group] <= merge(pcfg_r[dec.group],
                                               req.data, req.be);
                default:
                    ;
            endcase
        end
    end

    // Registers shared by all groups, a single copy each
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dac_r    <= `PTRMD_RST_REG;
            istat_r  <= `PTRMD_RST_REG;
            global_r <= `PTRMD_RST_REG;
            iq_r     <= `PTRMD_RST_REG;
        end
        else if (wr0)
        begin
            case (dec.kind)
                K_DAC:    dac_r    <= merge(dac_r, req.data, req.be);
                K_ISTAT:  istat_r  <= merge(istat_r, req.data, req.be);
                K_GLOBAL: global_r <= merge(global_r, req.data, req.be);
                K_IQ:     iq_r     <= merge(iq_r, req.data, req.be);
                default:  ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Service request launch: one pulse per write, group and command
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            srq_start <= 1'b0;
            srq_group <= 3'h0;
            srq_cmd   <= `PTRMD_RST_REG;
        end
        else
        begin
            srq_start <= wr0 && dec.kind == K_SRQ;
            if (wr0 && dec.kind == K_SRQ)
            begin
                srq_group <= dec.group;
                srq_cmd   <= merge(srq_r[dec.group], req.data, req.be);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data for non-RAM registers
    always_comb
    begin
        case (dec.kind)
            K_GBP:    rd_nxt = gbp_r[dec.group];
            K_DAC:    rd_nxt = dac_r;
            K_SRQ:    rd_nxt = srq_r[dec.group];
            K_ISTAT:  rd_nxt = istat_r;
            K_TXWO:   rd_nxt = `PTRMD_RD_ONES;
            K_GLOBAL: rd_nxt = global_r;
            K_IQ:     rd_nxt = iq_r;
            K_GRPCFG: rd_nxt = grpcfg_r[dec.group];
            K_MPROT:  rd_nxt = mprot_r[dec.group];
            K_MLEN:   rd_nxt = mlen_r[dec.group];
            K_PCFG:   rd_nxt = pcfg_r[dec.group];
            K_RXST:   rd_nxt = rx_selftest_in;
            K_TXST:   rd_nxt = tx_selftest_in;
            default:  rd_nxt = `PTRMD_RD_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: RAM reads take one wait state, expansion bus waits ack
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (accept && hit1)
                    state_nxt = ST_XBP;
                else if (accept && hit0 && !req.write &&
                         dec.kind == K_RAM)
                    state_nxt = ST_RAMRD;
            end
            ST_RAMRD:
                state_nxt = ST_IDLE;
            ST_XBP:
            begin
                if (xbp_ack)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r   <= ST_IDLE;
            req_ready <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            req_ready <= state_nxt == ST_IDLE;  // Stall while busy
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Response: unclaimed cycles report claimed low and no data
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            resp <= '0;
        else
        begin
            resp.valid <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (accept && !hit1 &&
                        !(hit0 && !req.write && dec.kind == K_RAM))
                    begin
                        resp.valid   <= 1'b1;
                        resp.claimed <= hit0;
                        resp.data    <= (hit0 && !req.write) ?
                                        rd_nxt : `PTRMD_RD_ZERO;
                    end
                end
                ST_RAMRD:
                begin
                    resp.valid   <= 1'b1;
                    resp.claimed <= 1'b1;
                    resp.data    <= ram_rdata;
                end
                ST_XBP:
                begin
                    if (xbp_ack)
                    begin
                        resp.valid   <= 1'b1;
                        resp.claimed <= 1'b1;
                        resp.data    <= xbp_out.write ?
                                        `PTRMD_RD_ZERO : xbp_rdata;
                    end
                end
                default:
                    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Expansion bus request held until the far side acknowledges
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            xbp_out <= '0;
        else if (state_r == ST_IDLE && accept && hit1)
        begin
            xbp_out.req   <= 1'b1;
            xbp_out.write <= req.write;
            xbp_out.addr  <= req.addr[19:0];
            xbp_out.wdata <= req.data;
            xbp_out.be    <= req.be;
        end
        else if (state_r == ST_XBP && xbp_ack)
            xbp_out.req <= 1'b0;
    end

endmodule : ptrmd_decoder

// ==== ptrmd_expansion_bus_port_model.sv ====
/*
 * Expansion bus peripheral model: acks after a set wait, answers reads
 * with an address-derived word and records the last write.
 * Assumes the decoder holds its request until the ack.
 */
`timescale 1ns/1ps

module ptrmd_xbp_model
(
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire ptrmd_pkg::ptrmd_xbp_type xbp_out,
    input  wire logic [3:0]               wait_cycles,
    output logic                          xbp_ack,
    output logic [31:0]                   xbp_rdata,
    output logic [31:0]                   last_wdata
);
    import ptrmd_pkg::*;

    logic [3:0] cnt_r;

    // Wait, ack one cycle; data off the ack is scrambled, never held
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r      <= 4'h0;
            xbp_ack    <= 1'b0;
            xbp_rdata  <= 32'h0;
            last_wdata <= 32'h0;
        end
        else if (xbp_out.req && !xbp_ack && cnt_r == wait_cycles)
        begin
            xbp_ack    <= 1'b1;
            xbp_rdata  <= {12'hE5B, xbp_out.addr};
            if (xbp_out.write)
                last_wdata <= xbp_out.wdata;
        end
        else
        begin
            cnt_r      <= (xbp_out.req && !xbp_ack) ? cnt_r + 4'h1 : 4'h0;
            xbp_ack    <= 1'b0;
            xbp_rdata  <= ~xbp_rdata;
        end
    end
endmodule : ptrmd_xbp_model

// ==== ptrmd_decoder_chk.sv ====
/*
 * Port checker for the register map decoder, bound to its top.
 * Assumes base registers change only by config writes at 10h.
 */
`timescale 1ns/1ps
`include "ptrmd_cfg.svh"

module ptrmd_decoder_chk
(
    input wire logic                      clk,
    input wire logic                      reset,
    input wire ptrmd_pkg::ptrmd_req_type  req,
    input wire logic                      req_ready,
    input wire ptrmd_pkg::ptrmd_resp_type resp,
    input wire ptrmd_pkg::ptrmd_cfg_type  cfg_req,
    input wire logic [31:0]               cfg_rdata,
    input wire ptrmd_pkg::ptrmd_xbp_type  xbp_out,
    input wire logic                      xbp_ack,
    input wire logic [31:0]               xbp_rdata,
    input wire logic                      srq_start,
    input wire logic [2:0]                srq_group,
    input wire logic [31:0]               srq_cmd,
    input wire logic [31:0]               rx_selftest_in,
    input wire logic [31:0]               tx_selftest_in
);
    import ptrmd_pkg::*;

    logic [31:0] bar0_r;
    logic [31:0] bar1_r;
    logic        tk;
    logic        h0;
    logic        h1;
    logic        rd0;

    // Taken, window hits, plain function 0 read inside the map
    assign tk  = req.valid && req_ready && !req.self_master;
    assign h0  = req.addr[31:20] == bar0_r[31:20];
    assign h1  = req.addr[31:20] == bar1_r[31:20];
    assign rd0 = tk && h0 && !req.write && req.addr[19:14] == 6'h00;

    // Shadow bases, so claims are judged without peeking inside
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bar0_r <= `PTRMD_RST_REG;
            bar1_r <= `PTRMD_RST_REG;
        end
        else if (cfg_req.valid && cfg_req.write
                 && cfg_req.offset == `PTRMD_BAR_CFG_OFF)
        begin
            if (cfg_req.func)
                bar1_r <= cfg_req.data & `PTRMD_BAR_MASK;
            else
                bar0_r <= cfg_req.data & `PTRMD_BAR_MASK;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    no_claim_a : assert property (
        req.valid && req_ready && (req.self_master || !h0 && !h1)
        |=> resp.valid && !resp.claimed && resp.data == 32'h0)
        else $error("foreign or own cycle was claimed");
    f0_answer_a : assert property (
        tk && h0 |-> ##[1:2] resp.valid && resp.claimed)
        else $error("function 0 access not answered");
    xbp_req_a : assert property (
        tk && h1 && !h0 |=> xbp_out.req
        && xbp_out.addr == $past(req.addr[19:0]))
        else $error("bus request missing");
    xbp_rd_a : assert property (
        xbp_out.req && !xbp_out.write && xbp_ack
        |=> resp.valid && resp.data == $past(xbp_rdata))
        else $error("bus read data lost");
    tx_ones_a : assert property (
        rd0 && req.addr[10:0] >= 11'h200 && req.addr[10:0] < 11'h380
        |=> resp.valid && resp.data == `PTRMD_RD_ONES)
        else $error("write-only map read not all ones");
    selftest_a : assert property (
        rd0 && req.addr[10:0] == `PTRMD_OFF_RXST
        |=> resp.data == $past(rx_selftest_in))
        else $error("self-test status read wrong");
    srq_go_a : assert property (
        tk && h0 && req.write && req.addr[19:14] == 6'h00
        && req.addr[10:0] == `PTRMD_OFF_SRQ
        |=> srq_start && srq_group == $past(req.addr[13:11]))
        else $error("service request not launched");
    undef_a : assert property (
        tk && h0 && !req.write && req.addr[19:14] != 6'h00
        |=> resp.valid && resp.claimed && resp.data == 32'h0)
        else $error("undefined offset read not zero");
    cfg_rd_a : assert property (
        cfg_req.valid && !cfg_req.write
        && cfg_req.offset == `PTRMD_BAR_CFG_OFF
        |=> cfg_rdata == ($past(cfg_req.func) ? bar1_r : bar0_r))
        else $error("base address readback wrong");

    cover property (tk && h1 && !h0);
    cover property (srq_start);
    cover property (rd0 && req.addr[10:0] == `PTRMD_OFF_TXSLOT);
endmodule : ptrmd_decoder_chk

bind ptrmd_decoder ptrmd_decoder_chk i_chk (.*);

// ==== ptrmd_decoder_tb.sv ====
/*
 * Self-checking bench for the register map decoder.
 * Assumes the partner model and bound checker are compiled.
 */
`timescale 1ns/1ps

module ptrmd_decoder_tb;
    import ptrmd_pkg::*;

    localparam logic [31:0] B0 = 32'h0240_0000, B1 = 32'h0340_0000,
        RXS = 32'h1357_9BDF, TXS = 32'h2468_ACE0,
        ONES = 32'hFFFF_FFFF;

    logic           clk = 1'b0;
    logic           reset = 1'b1;
    ptrmd_req_type  req = '0;
    ptrmd_cfg_type  cfg_req = '0;
    ptrmd_resp_type resp;
    ptrmd_xbp_type  xbp_out;
    logic           req_ready;
    logic           xbp_ack;
    logic           srq_start;
    logic [2:0]     srq_group;
    logic [3:0]     wait_cycles = 4'h0;
    logic [31:0]    cfg_rdata;
    logic [31:0]    xbp_rdata;
    logic [31:0]    srq_cmd;
    logic [31:0]    last_wdata;
    int             mismatches = 0;
    int             check_count = 0;

    always #50 clk = ~clk;

    ptrmd_decoder i_ptrmd_decoder (.*, .rx_selftest_in(RXS),
        .tx_selftest_in(TXS));
    ptrmd_xbp_model i_ptrmd_xbp_model (.*);

    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, exp, input string m);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, seen, exp);
        end
    endtask : chk

    // Hold the cycle until taken, then wait a bounded time for the answer
    task automatic acc(input logic [31:0] a, d, input logic w, s);
        int n = 0;
        @(posedge clk) req <= '{1'b1, w, s, a, d, 4'hF};
        do @(negedge clk) n++; while (req_ready !== 1'b1 && n < 40);
        @(posedge clk) req <= '0;
        do @(negedge clk) n++; while (resp.valid !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            mismatches++;
            conclude();
        end
    endtask : acc

    task automatic rd(input logic [31:0] a, input logic c,
                      input logic [31:0] e, input string m);
        acc(a, 32'h0, 1'b0, 1'b0);
        chk(resp.claimed, c, m);
        chk(resp.data, e, m);
    endtask : rd

    // Config cycle; reads are judged the cycle after they are taken
    task automatic cfg(input logic w, f, input logic [7:0] o,
                       input logic [31:0] d);
        @(posedge clk) cfg_req <= '{1'b1, w, f, o, d};
        @(posedge clk) cfg_req <= '0;
        @(negedge clk);
    endtask : cfg

    ////////////////////////////////////////////////////////////////////
    task automatic t_config;
        cfg(1'b1, 1'b0, 8'h10, B0 | 32'h000A_BC00);
        cfg(1'b1, 1'b1, 8'h10, B1);
        cfg(1'b0, 1'b0, 8'h10, 32'h0);
        chk(cfg_rdata, B0, "base 0");
        cfg(1'b0, 1'b1, 8'h10, 32'h0);
        chk(cfg_rdata, B1, "base 1");
    endtask : t_config

    task automatic t_claim;
        rd(B0 + 32'h0010_0000, 1'b0, 32'h0, "outside");
        acc(B0 | 32'h600, 32'h0, 1'b0, 1'b1);
        chk(resp.claimed, 1'b0, "own cycle");
        rd(B0 | 32'hF_FFFC, 1'b1, 32'h0, "window top");
        rd(B0 | 32'h1FC, 1'b1, 32'h0, "below tx map");
        rd(B0 | 32'h644, 1'b1, TXS, "tx self-test");
        rd(B0 | 32'h640, 1'b1, RXS, "rx self-test");
    endtask : t_claim

    task automatic t_shared;
        logic [10:0] offs [4] = '{11'h004, 11'h00C, 11'h600, 11'h604};
        for (int i = 0; i < 4; i++)
        begin
            acc(B0 | (i + 3) * 32'h800 | offs[i], 32'h5A00 + i, 1'b1, 1'b0);
            rd(B0 | offs[i], 1'b1, 32'h5A00 + i, "shared");
        end
    endtask : t_shared

    task automatic t_groups;
        logic [10:0] offs [9] = '{11'h000, 11'h380, 11'h400, 11'h480,
            11'h580, 11'h60C, 11'h610, 11'h614, 11'h618};
        for (int g = 0; g < 8; g++)
            for (int j = 0; j < 9; j++)
                acc(B0 | g * 32'h800 | offs[j], 32'hC0DE_0000 | g << 12
                    | offs[j], 1'b1, 1'b0);
        for (int g = 0; g < 8; g++)
        begin
            acc(B0 | g * 32'h800 | 32'h200, 32'h1, 1'b1, 1'b0);
            rd(B0 | g * 32'h800 | 32'h200, 1'b1, ONES, "tx slot");
            rd(B0 | g * 32'h800 | 32'h37C, 1'b1, ONES, "tx sub");
            for (int j = 0; j < 9; j++)
                rd(B0 | g * 32'h800 | offs[j], 1'b1, 32'hC0DE_0000
                   | g << 12 | offs[j], "group reg");
        end
    endtask : t_groups

    task automatic t_srq;
        acc(B0 | 32'h1008, 32'h0000_1234, 1'b1, 1'b0);
        chk(srq_start, 1'b1, "srq pulse");
        chk(srq_group, 3'h2, "srq group");
        chk(srq_cmd, 32'h0000_1234, "srq command");
    endtask : t_srq

    // Expansion bus both prompt and slow
    task automatic t_xbp;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) wait_cycles <= i ? 4'h6 : 4'h0;
            acc(B1 | 32'h1234, 32'h7700 + i, 1'b1, 1'b0);
            chk(last_wdata, 32'h7700 + i, "bus write");
            rd(B1 | 32'h10, 1'b1, 32'hE5B0_0010, "bus read");
        end
    endtask : t_xbp

    ////////////////////////////////////////////////////////////////////
    // Reset, then two edges of grace before the first cycle
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_config();
        t_claim();
        t_shared();
        t_groups();
        t_srq();
        t_xbp();
        conclude();
    end
endmodule : ptrmd_decoder_tb
